/* design/unr_defs.svh */
// Constants for the user nonvolatile ROM port
`ifndef UNR_DEFS_SVH
`define UNR_DEFS_SVH
`define UNR_NUM_BANKS     8
`define UNR_BANK_BITS     128
`define UNR_ADDR_BITS     7
`define UNR_BANK_MSB      6
`define UNR_BANK_LSB      4
`define UNR_BYTE_MSB      3
`define UNR_BYTE_LSB      0
`define UNR_ERASED_VALUE  128'hFFFFFFFF_FFFFFFFF_FFFFFFFF_FFFFFFFF
`define UNR_RD_RESET      8'h00
`define UNR_DEC_CYCLES    10
`endif

/* design/unr_pkg.sv */
// Types for the user nonvolatile ROM port
package unr_pkg;
    typedef enum logic [1:0] {
        UNR_IDLE    = 2'b00,
        UNR_DECRYPT = 2'b01,
        UNR_EXEC    = 2'b11
    } unr_state_e;

    typedef enum logic [1:0] {
        UNR_CMD_NOP   = 2'b00,
        UNR_CMD_ERASE = 2'b01,
        UNR_CMD_WRITE = 2'b10,
        UNR_CMD_READ  = 2'b11
    } unr_cmd_e;
endpackage

/* design/unr_decrypt.sv */
// Keyed decryption stage for programming data
`timescale 1ns/1ns
`default_nettype none
`include "unr_defs.svh"
module unr_decrypt #(
    parameter int W      = `UNR_BANK_BITS,
    parameter int CYCLES = `UNR_DEC_CYCLES
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         start_i,
    input  wire logic [W-1:0] cipher_i,
    input  wire logic [W-1:0] key_i,
    output logic              valid_o,
    output logic [W-1:0]      plain_o
);
    initial begin
        if (W < 8 || CYCLES < 1 || CYCLES > 255) $error("unr_decrypt: bad parameters");
    end

    logic [7:0]   cnt_q, cnt_d;
    logic         valid_q, valid_d;
    logic [W-1:0] plain_q, plain_d;

    // Fixed latency keeps the write path timing independent of data
    always_comb begin
        cnt_d   = cnt_q;
        valid_d = 1'b0;
        plain_d = plain_q;
        if (start_i) begin
            cnt_d   = 8'(CYCLES);
            plain_d = cipher_i;
        end else if (cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
                valid_d = 1'b1;
                plain_d = plain_q ^ key_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q   <= 8'h00;
            valid_q <= 1'b0;
            plain_q <= '0;
        end else begin
            cnt_q   <= cnt_d;
            valid_q <= valid_d;
            plain_q <= plain_d;
        end
    end

    assign valid_o = valid_q;
    assign plain_o = plain_q;
endmodule
`default_nettype wire

/* design/unr_rom_port.sv */
// User nonvolatile ROM: programming port and core byte read port
`timescale 1ns/1ns
`default_nettype none
`include "unr_defs.svh"
module unr_rom_port
    import unr_pkg::*;
#(
    parameter int NUM_BANKS = `UNR_NUM_BANKS,
    parameter int BANK_BITS = `UNR_BANK_BITS
) (
    input  wire logic                   SYS_CLK_I,
    input  wire logic                   RST_B_I,
    // Core side, same clock
    input  wire logic                   CORE_RD_EN_I,
    input  wire logic [6:0]             CORE_ADDR_I,
    input  wire logic                   CORE_WR_I,
    output logic [7:0]                  CORE_RD_DATA_O,
    output logic                        CORE_WR_REJ_O,
    // Programming port, asynchronous pins
    input  wire logic                   PROG_STB_I,
    input  wire logic [1:0]             PROG_CMD_I,
    input  wire logic [2:0]             PROG_BANK_I,
    input  wire logic                   PROG_DECRYPT_I,
    input  wire logic [BANK_BITS-1:0]   PROG_DATA_I,
    input  wire logic [BANK_BITS-1:0]   PROG_KEY_I,
    output logic [BANK_BITS-1:0]        PROG_RDATA_O,
    output logic                        PROG_DONE_O,
    output logic                        PROG_BUSY_O
);
    initial begin
        if (NUM_BANKS != `UNR_NUM_BANKS || BANK_BITS != `UNR_BANK_BITS)
            $error("unr_rom_port: address map needs 8 banks of 128 bits");
    end

    localparam int SW = 1 + 2 + 3 + 1 + 2 * BANK_BITS;

    function automatic logic [7:0] pick_byte(input logic [BANK_BITS-1:0] bank,
                                             input logic [3:0] idx);
        pick_byte = bank[idx*8 +: 8];
    endfunction

    // Two-flop synchronisers; pins must be held stable around the strobe
    logic [SW-1:0]        s1_q, s2_q;
    logic                 stb_last_q;
    logic                 stb_s;
    logic [1:0]           cmd_s;
    logic [2:0]           bank_s;
    logic                 dec_s;
    logic [BANK_BITS-1:0] data_s, key_s;

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            s1_q       <= '0;
            s2_q       <= '0;
            stb_last_q <= 1'b0;
        end else begin
            s1_q       <= {PROG_STB_I, PROG_CMD_I, PROG_BANK_I, PROG_DECRYPT_I,
                           PROG_DATA_I, PROG_KEY_I};
            s2_q       <= s1_q;
            stb_last_q <= stb_s;
        end
    end
    assign {stb_s, cmd_s, bank_s, dec_s, data_s, key_s} = s2_q;

    // Storage is nonvolatile: never cleared by reset
    logic [BANK_BITS-1:0] mem_q [NUM_BANKS];

    unr_state_e           st_q, st_d;
    unr_cmd_e             cmd_q, cmd_d;
    logic [2:0]           bank_q, bank_d;
    logic [BANK_BITS-1:0] pay_q, pay_d;
    logic [BANK_BITS-1:0] prd_q, prd_d;
    logic                 done_q, done_d;
    logic                 busy_q, busy_d;
    logic                 dec_start;
    logic                 dec_valid;
    logic [BANK_BITS-1:0] dec_plain;

    always_comb begin
        st_d      = st_q;
        cmd_d     = cmd_q;
        bank_d    = bank_q;
        pay_d     = pay_q;
        prd_d     = prd_q;
        done_d    = 1'b0;
        dec_start = 1'b0;
        case (st_q)
            UNR_IDLE: begin
                // Strobes during an operation are dropped
                if (stb_s && !stb_last_q && unr_cmd_e'(cmd_s) != UNR_CMD_NOP) begin
                    cmd_d  = unr_cmd_e'(cmd_s);
                    bank_d = bank_s;
                    pay_d  = data_s;
                    if (dec_s && unr_cmd_e'(cmd_s) == UNR_CMD_WRITE) begin
                        dec_start = 1'b1;
                        st_d      = UNR_DECRYPT;
                    end else begin
                        st_d = UNR_EXEC;
                    end
                end
            end
            UNR_DECRYPT: begin
                if (dec_valid) begin
                    pay_d = dec_plain;
                    st_d  = UNR_EXEC;
                end
            end
            UNR_EXEC: begin
                if (cmd_q == UNR_CMD_READ)
                    prd_d = mem_q[bank_q];
                done_d = 1'b1;
                st_d   = UNR_IDLE;
            end
            default: st_d = UNR_IDLE;
        endcase
        // Registered so the pin never glitches on a state decode
        busy_d = (st_d != UNR_IDLE);
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            st_q   <= UNR_IDLE;
            cmd_q  <= UNR_CMD_NOP;
            bank_q <= 3'h0;
            pay_q  <= '0;
            prd_q  <= '0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            cmd_q  <= cmd_d;
            bank_q <= bank_d;
            pay_q  <= pay_d;
            prd_q  <= prd_d;
            done_q <= done_d;
            busy_q <= busy_d;
        end
    end

    // Only the programming sequencer has a path into the array
    logic                 mem_we;
    logic [BANK_BITS-1:0] mem_wd;
    always_comb begin
        mem_we = (st_q == UNR_EXEC) && (cmd_q == UNR_CMD_ERASE || cmd_q == UNR_CMD_WRITE);
        mem_wd = (cmd_q == UNR_CMD_ERASE) ? `UNR_ERASED_VALUE : pay_q;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (mem_we)
            mem_q[bank_q] <= mem_wd;
    end

    unr_decrypt #(
        .W      (BANK_BITS),
        .CYCLES (`UNR_DEC_CYCLES)
    ) u_decrypt (
        .clk_i    (SYS_CLK_I),
        .rst_b_i  (RST_B_I),
        .start_i  (dec_start),
        // Synced pin data: pay_q still holds the previous operation here
        .cipher_i (data_s),
        .key_i    (key_s),
        .valid_o  (dec_valid),
        .plain_o  (dec_plain)
    );

    // Core read port
    logic [2:0] rd_bank;
    logic [3:0] rd_byte;
    logic [7:0] rd_sel;
    logic [7:0] rd_q, rd_d;
    logic       rej_q, rej_d;

    always_comb begin
        rd_bank = CORE_ADDR_I[`UNR_BANK_MSB:`UNR_BANK_LSB];
        rd_byte = CORE_ADDR_I[`UNR_BYTE_MSB:`UNR_BYTE_LSB];
        rd_sel  = pick_byte(mem_q[rd_bank], rd_byte);
        rd_d    = CORE_RD_EN_I ? rd_sel : rd_q;
        rej_d   = CORE_WR_I;
    end

    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rd_q  <= `UNR_RD_RESET;
            rej_q <= 1'b0;
        end else begin
            rd_q  <= rd_d;
            rej_q <= rej_d;
        end
    end

    assign CORE_RD_DATA_O = rd_q;
    assign CORE_WR_REJ_O  = rej_q;
    assign PROG_RDATA_O   = prd_q;
    assign PROG_DONE_O    = done_q;
    assign PROG_BUSY_O    = busy_q;

    // Checks
    logic [NUM_BANKS*BANK_BITS-1:0] mem_flat;
    always_comb begin
        for (int i = 0; i < NUM_BANKS; i++)
            mem_flat[i*BANK_BITS +: BANK_BITS] = mem_q[i];
    end

    a_read_byte: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        CORE_RD_EN_I |=> CORE_RD_DATA_O == $past(rd_sel))
        else $error("core read byte wrong");
    a_read_hold: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        !CORE_RD_EN_I |=> $stable(CORE_RD_DATA_O))
        else $error("core read data moved without a read");
    a_bank_decode: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        CORE_RD_EN_I |=> CORE_RD_DATA_O == $past(mem_flat[{CORE_ADDR_I, 3'b000} +: 8]))
        else $error("bank or byte decode wrong");
    a_core_no_write: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (CORE_WR_I && st_q != UNR_EXEC) |=> $stable(mem_flat))
        else $error("core write altered storage");
    a_write_reject: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        CORE_WR_I |=> CORE_WR_REJ_O)
        else $error("core write not flagged");
    a_erase_bank: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (st_q == UNR_EXEC && cmd_q == UNR_CMD_ERASE) |=>
            mem_q[$past(bank_q)] == `UNR_ERASED_VALUE && PROG_DONE_O)
        else $error("erase did not clear bank");
    a_write_bank: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (st_q == UNR_EXEC && cmd_q == UNR_CMD_WRITE) |=> mem_q[$past(bank_q)] == $past(pay_q))
        else $error("write did not store bank");
    a_readback: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        (st_q == UNR_EXEC && cmd_q == UNR_CMD_READ) |=> PROG_RDATA_O == $past(mem_q[bank_q]))
        else $error("programming readback wrong");
    a_decrypt_time: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        dec_start |=> st_q == UNR_DECRYPT ##10 st_q == UNR_DECRYPT ##1 st_q == UNR_EXEC)
        else $error("decrypt latency wrong");

    c_core_read:  cover property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        CORE_RD_EN_I ##1 CORE_RD_EN_I && $changed(CORE_ADDR_I));
    c_dec_write:  cover property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        dec_start ##[1:20] PROG_DONE_O);
    c_erase:      cover property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        st_q == UNR_EXEC && cmd_q == UNR_CMD_ERASE);
    c_core_wr:    cover property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        CORE_WR_I && CORE_RD_EN_I);
endmodule
`default_nettype wire

/* tb/unr_core_user.sv */
// Core-fabric user logic issuing byte reads and write attempts
`timescale 1ns/1ns
`default_nettype none
module unr_core_user (
    input  wire logic       clk_i,
    input  wire logic [7:0] rd_data_i,
    output logic            rd_en_o,
    output logic [6:0]      addr_o,
    output logic            wr_o
);
    initial begin
        rd_en_o = 1'b0;
        addr_o  = 7'h00;
        wr_o    = 1'b0;
    end
    // Address toggles while idle so a stale hold cannot look right
    task automatic idle(input int n);
        for (int i = 0; i < n; i++) begin
            rd_en_o = 1'b0;
            addr_o  = ~addr_o;
            @(negedge clk_i);
        end
    endtask
    // Entered on a falling edge; returns on the falling edge after the read
    task automatic rd(input logic [6:0] a, input int gap, output logic [7:0] d);
        idle(gap);
        rd_en_o = 1'b1;
        addr_o  = a;
        @(negedge clk_i);
        d = rd_data_i;
    endtask
    task automatic wr_try(input logic [6:0] a);
        rd_en_o = 1'b0;
        wr_o    = 1'b1;
        addr_o  = a;
        @(negedge clk_i);
        wr_o    = 1'b0;
    endtask
endmodule
`default_nettype wire

/* tb/test_unr_rom_port.sv */
// Self-checking bench for the user nonvolatile ROM port
`timescale 1ns/1ns
`default_nettype none
module test_unr_rom_port;
    logic         sys_clk, rst_b, rd_en, wr, stb, dec, rej, done, busy;
    logic [6:0]   addr;
    logic [7:0]   rdata, d, d0;
    logic [1:0]   cmd;
    logic [2:0]   bank;
    logic [127:0] pdata, pkey, prd;
    logic [127:0] model [8];
    int           err_total, check_count, cycles, seed;

    unr_rom_port unr_rom_port_inst (
        .SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .CORE_RD_EN_I(rd_en),
        .CORE_ADDR_I(addr), .CORE_WR_I(wr), .CORE_RD_DATA_O(rdata),
        .CORE_WR_REJ_O(rej), .PROG_STB_I(stb), .PROG_CMD_I(cmd),
        .PROG_BANK_I(bank), .PROG_DECRYPT_I(dec), .PROG_DATA_I(pdata),
        .PROG_KEY_I(pkey), .PROG_RDATA_O(prd), .PROG_DONE_O(done),
        .PROG_BUSY_O(busy));
    unr_core_user unr_core_user_inst (
        .clk_i(sys_clk), .rd_data_i(rdata), .rd_en_o(rd_en), .addr_o(addr), .wr_o(wr));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Inputs held from one cycle before the strobe until done
    task automatic prog(input logic [1:0] c, input logic [2:0] b, input logic x,
                        input logic [127:0] w, input logic [127:0] k);
        int n;
        logic bz;
        n = 0;
        bz = 1'b0;
        cmd = c;
        bank = b;
        dec = x;
        pdata = w;
        pkey = k;
        @(negedge sys_clk);
        stb = 1'b1;
        while (done !== 1'b1 && n < 60) begin
            @(negedge sys_clk);
            n++;
            if (busy === 1'b1)
                bz = 1'b1;
        end
        chk("prog_done", {127'h0, done}, 128'h1);
        chk("prog_busy", {126'h0, bz, busy}, 128'h2);
        stb = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask
    function automatic logic [127:0] rnd128();
        return {$random(seed), $random(seed), $random(seed), $random(seed)};
    endfunction

    initial begin
        seed = 32;
        err_total = 0;
        check_count = 0;
        cycles = 0;
        rst_b = 1'b0;
        {stb, dec, cmd, bank} = '0;
        pdata = '0;
        pkey = '0;
        repeat (5) @(negedge sys_clk);
        chk("rd_data_rst", {120'h0, rdata}, 128'h0);
        chk("flags_rst", {125'h0, rej, done, busy}, 128'h0);
        rst_b = 1'b1;
        @(negedge sys_clk);
        $display("test reset done");
        for (int b = 0; b < 8; b++) begin
            pdata = rnd128();
            pkey = rnd128();
            model[b] = b[0] ? pdata ^ pkey : pdata;
            prog(2'b10, b[2:0], b[0], pdata, pkey);
        end
        $display("test program banks done");
        for (int a = 0; a < 128; a++) begin
            unr_core_user_inst.rd(a[6:0], a % 3, d);
            chk("core_byte", {120'h0, d}, {120'h0, model[a[6:4]][8*a[3:0] +: 8]});
        end
        $display("test core reads done");
        unr_core_user_inst.rd(7'h25, 0, d0);
        unr_core_user_inst.idle(4);
        chk("rd_first", {120'h0, d0}, {120'h0, model[2][47:40]});
        chk("rd_hold", {120'h0, rdata}, {120'h0, model[2][47:40]});
        $display("test hold done");
        unr_core_user_inst.wr_try(7'h5A);
        chk("wr_rej", {127'h0, rej}, 128'h1);
        unr_core_user_inst.rd(7'h5A, 1, d);
        chk("wr_ignored", {120'h0, d}, {120'h0, model[5][87:80]});
        $display("test core write refused done");
        cmd = 2'b00;
        @(negedge sys_clk);
        stb = 1'b1;
        repeat (6) begin
            @(negedge sys_clk);
            chk("nop_idle", {126'h0, busy, done}, 128'h0);
        end
        stb = 1'b0;
        repeat (3) @(negedge sys_clk);
        $display("test nop ignored done");
        prog(2'b01, 3'd3, 1'b0, rnd128(), rnd128());
        model[3] = {128{1'b1}};
        for (int b = 0; b < 8; b++) begin
            prog(2'b11, b[2:0], 1'b0, pdata, pkey);
            chk("prog_rdata", prd, model[b]);
        end
        unr_core_user_inst.rd(7'h3F, 0, d);
        chk("erased_byte", {120'h0, d}, {120'h0, 8'hFF});
        $display("test erase and readback done");
        final_report();
    end
endmodule
`default_nettype wire
